// *** rtl/supply_supervisor.sv ***
// reset, regulator and gate-drive undervoltage supervisor with apb registers
// Behaviour
// - regulator on and reset released only after some wake input goes high
// - keep-on bit set holds regulator on and normal mode without wake
// - keep-on clear and no wake: enter reset, regulator off
// - power-up release needs both low-voltage and battery supplies good
// - undervoltage lockout turns booster off below detection level
// - undervoltage detection ignored for 150 us after power-on reset
// - 3-bit threshold field sets detection level relative to setpoint
// - threshold zero disables the undervoltage lockout entirely
// - 4-bit setpoint field selects one of 16 gate-drive levels
// - all logic and timing run from the internal rc clock
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "supply_sup_defines.svh"
module supply_supervisor import supply_sup_pkg::*; #(
   parameter int BLANK_CYCLES = `BLANK_CYCLES,
   parameter int WAKE_N = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [WAKE_N-1:0] wake_inputs,
   input wire logic low_supply_good,
   input wire logic battery_supply_good,
   input wire logic drive_uv_detect,
   output logic regulator_on_ff,
   output logic chip_reset_n_ff,
   output logic booster_allow_ff,
   output logic [3:0] drive_supply_setpoint_ff,
   output logic [2:0] drive_uv_threshold_ff
);
   // all counting uses pclk, the internal rc clock
   logic [WAKE_N+2:0] raw_in;
   logic [WAKE_N+2:0] sync_in;
   logic [WAKE_N-1:0] wake_s;
   logic vdd_ok_s;
   logic battery_ok_s;
   logic uv_s;
   sup_state_e state_ff;
   sup_state_e nxt_state;
   sup_cfg_s cfg_ff;
   logic [31:0] blank_cnt_ff;
   logic stay_on;
   logic supplies_ok;
   logic wr_en;
   logic rd_en;
   logic uv_active;

   assign raw_in = {drive_uv_detect, battery_supply_good, low_supply_good,
      wake_inputs};

   sync2 #(.WIDTH(WAKE_N+3)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(raw_in),
      .dout(sync_in)
   );

   assign wake_s = sync_in[WAKE_N-1:0];
   assign vdd_ok_s = sync_in[WAKE_N];
   assign battery_ok_s = sync_in[WAKE_N+1];
   assign uv_s = sync_in[WAKE_N+2];

   function automatic logic word_hit(input logic [11:0] a,
      input logic [11:0] ofs);
      word_hit = (a[11:2] == ofs[11:2]);
   endfunction

   assign supplies_ok = vdd_ok_s && battery_ok_s;
   assign stay_on = (|wake_s) || cfg_ff.regulator_keep_on;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   // lockout active only when threshold nonzero and undervoltage detected
   assign uv_active = (cfg_ff.drive_uv_threshold != 3'h0) && uv_s;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_OFF: begin
            if ((|wake_s) && supplies_ok) begin
               nxt_state = ST_BLANK;
            end
         end
         ST_BLANK: begin
            if (!stay_on || !supplies_ok) begin
               nxt_state = ST_OFF;
            end else if (blank_cnt_ff == 32'(BLANK_CYCLES - 1)) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!stay_on || !supplies_ok) begin
               nxt_state = ST_OFF;
            end
         end
         default: nxt_state = ST_OFF;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // blanking counter after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_cnt_ff <= 32'h0;
      end else if (state_ff == ST_BLANK) begin
         blank_cnt_ff <= blank_cnt_ff + 32'h1;
      end else begin
         blank_cnt_ff <= 32'h0;
      end
   end

   // software settings; cleared while the chip sits in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= '{`RST_KEEP_ON, `RST_SETPOINT, `RST_UV_THR};
      end else if (state_ff == ST_OFF) begin
         cfg_ff <= '{`RST_KEEP_ON, `RST_SETPOINT, `RST_UV_THR};
      end else if (wr_en && word_hit(paddr, `OFS_CTRL)) begin
         cfg_ff.regulator_keep_on <= pwdata[`CTRL_KEEP_ON_BIT];
      end else if (wr_en && word_hit(paddr, `OFS_DRIVE)) begin
         cfg_ff.drive_supply_setpoint <=
            pwdata[`DRIVE_SETPOINT_LSB +: 4];
         cfg_ff.drive_uv_threshold <= pwdata[`DRIVE_UV_THR_LSB +: 3];
      end
   end

   // outputs, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regulator_on_ff <= 1'b0;
         chip_reset_n_ff <= 1'b0;
         booster_allow_ff <= 1'b0;
         drive_supply_setpoint_ff <= 4'h0;
         drive_uv_threshold_ff <= 3'h0;
      end else begin
         regulator_on_ff <= (nxt_state != ST_OFF);
         chip_reset_n_ff <= (nxt_state != ST_OFF);
         booster_allow_ff <= (nxt_state == ST_RUN) && !uv_active;
         drive_supply_setpoint_ff <= cfg_ff.drive_supply_setpoint;
         drive_uv_threshold_ff <= cfg_ff.drive_uv_threshold;
      end
   end

   // apb slave: zero wait states, unmapped addresses give pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !(word_hit(paddr, `OFS_CTRL) ||
            word_hit(paddr, `OFS_DRIVE) || word_hit(paddr, `OFS_STATUS) ||
            word_hit(paddr, `OFS_ID));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (rd_en) begin
         if (word_hit(paddr, `OFS_CTRL)) begin
            prdata <= {31'h0, cfg_ff.regulator_keep_on};
         end else if (word_hit(paddr, `OFS_DRIVE)) begin
            prdata <= {25'h0, cfg_ff.drive_uv_threshold,
               cfg_ff.drive_supply_setpoint};
         end else if (word_hit(paddr, `OFS_STATUS)) begin
            prdata <= {24'h0, uv_s, booster_allow_ff, battery_ok_s, vdd_ok_s,
               1'b0, state_ff};
         end else if (word_hit(paddr, `OFS_ID)) begin
            prdata <= `ID_VALUE; // arbitrary value
         end else begin
            prdata <= 32'h0;
         end
      end
   end

   // assertions
   AST_OFF_WITHOUT_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff != ST_OFF) && !stay_on |=> state_ff == ST_OFF)
      else $error("no wake and no keep-on did not enter reset");
   AST_KEEP_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
      state_ff == ST_RUN && cfg_ff.regulator_keep_on && supplies_ok
      |=> state_ff == ST_RUN)
      else $error("keep-on did not hold normal mode");
   AST_LEAVE_NEEDS_WAKE: assert property (@(posedge pclk)
      disable iff (!presetn)
      state_ff == ST_OFF ##1 state_ff != ST_OFF |-> $past(|wake_s))
      else $error("left reset without a wake input");
   AST_SUPPLIES: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(chip_reset_n_ff) |-> $past(supplies_ok))
      else $error("released with a supply low");
   AST_UV_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      uv_active |=> !booster_allow_ff)
      else $error("booster left on under undervoltage");
   AST_BLANK: assert property (@(posedge pclk) disable iff (!presetn)
      state_ff == ST_RUN |-> $past(blank_cnt_ff) ==
      32'(BLANK_CYCLES - 1) || $past(state_ff) == ST_RUN)
      else $error("blanking interval cut short");
   AST_THR_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      state_ff == ST_RUN && nxt_state == ST_RUN &&
      cfg_ff.drive_uv_threshold == 3'h0 |=> booster_allow_ff)
      else $error("disabled lockout still blocked booster");
   AST_CFG_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      state_ff == ST_OFF |=> !cfg_ff.regulator_keep_on &&
      cfg_ff.drive_uv_threshold == 3'h0)
      else $error("settings kept across reset");
   AST_SETPOINT: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && word_hit(paddr, `OFS_DRIVE) && state_ff != ST_OFF
      |=> ##1 drive_supply_setpoint_ff == $past(pwdata[3:0], 2))
      else $error("setpoint not applied");
   COV_RUN: cover property (@(posedge pclk) state_ff == ST_RUN);
   COV_KEEP: cover property (@(posedge pclk)
      state_ff == ST_RUN && wake_s == '0);
   COV_UV: cover property (@(posedge pclk) uv_active && state_ff == ST_RUN);
endmodule // supply_supervisor

// *** rtl/supply_sup_defines.svh ***
// register offsets, field layouts, reset values and timing counts
`ifndef SUPPLY_SUP_DEFINES_SVH
`define SUPPLY_SUP_DEFINES_SVH
`define OFS_CTRL 12'h000
`define OFS_DRIVE 12'h004
`define OFS_STATUS 12'h008
`define OFS_ID 12'h00C
`define CTRL_KEEP_ON_BIT 0
`define DRIVE_SETPOINT_LSB 0
`define DRIVE_UV_THR_LSB 4
`define RST_KEEP_ON 1'b0
`define RST_SETPOINT 4'h0
`define RST_UV_THR 3'h0
`define BLANK_TIME_US 150
`define CLK_MHZ 20
`define BLANK_CYCLES (`BLANK_TIME_US * `CLK_MHZ)
`define ID_VALUE 32'h5A5A0001
`endif

// *** rtl/supply_sup_pkg.sv ***
// types shared by the supply supervisor
package supply_sup_pkg;
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_BLANK = 3'b010,
      ST_RUN = 3'b100
   } sup_state_e;
   typedef struct packed {
      logic regulator_keep_on;
      logic [3:0] drive_supply_setpoint;
      logic [2:0] drive_uv_threshold;
   } sup_cfg_s;
endpackage

// *** rtl/sync2.sv ***
// two-flop synchroniser for a bus of levels
`timescale 1ns/1ns
module sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= '0;
         dout <= '0;
      end else begin
         meta_ff <= din;
         dout <= meta_ff;
      end
   end
endmodule // sync2

// *** test/wake_host_model.sv ***
// host side model that drives the wake pins from a bench request
`timescale 1ns/1ns
module wake_host_model (
   input wire logic pclk,
   input wire logic [2:0] wake_req,
   output logic [2:0] wake_inputs = 3'h0
);
   // pins change just after a rising edge, like a clocked host port
   always @(posedge pclk) begin
      wake_inputs <= wake_req;
   end
endmodule // wake_host_model

// *** test/enable_and_drive_supply_supervisor_bench.sv ***
// self-checking bench for the supply supervisor
`timescale 1ns/1ns
`include "supply_sup_defines.svh"
module enable_and_drive_supply_supervisor_bench import supply_sup_pkg::*;;
   typedef struct packed {
      logic [2:0] w;
      logic lg;
      logic bg;
      logic on;
   } row_s;
   row_s rows [7] = '{'{3'h1, 1'b1, 1'b1, 1'b1}, '{3'h2, 1'b1, 1'b1, 1'b1},
      '{3'h4, 1'b1, 1'b1, 1'b1}, '{3'h7, 1'b1, 1'b1, 1'b1},
      '{3'h0, 1'b1, 1'b1, 1'b0}, '{3'h3, 1'b0, 1'b1, 1'b0},
      '{3'h5, 1'b1, 1'b0, 1'b0}};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, er;
   logic [2:0] wake_req = 3'h0;
   logic [2:0] wake_inputs;
   logic low_good = 1'b1;
   logic bat_good = 1'b1;
   logic uv = 1'b0;
   logic reg_on, rst_n, boost_ok;
   logic [3:0] setpt;
   logic [2:0] thr;
   int n_errors = 0;
   int comparisons = 0;

   always #25 pclk = ~pclk;

   wake_host_model i_host (.pclk(pclk), .wake_req(wake_req),
      .wake_inputs(wake_inputs));
   supply_supervisor #(.BLANK_CYCLES(10), .WAKE_N(3)) i_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wake_inputs(wake_inputs),
      .low_supply_good(low_good), .battery_supply_good(bat_good),
      .drive_uv_detect(uv), .regulator_on_ff(reg_on),
      .chip_reset_n_ff(rst_n), .booster_allow_ff(boost_ok),
      .drive_supply_setpoint_ff(setpt), .drive_uv_threshold_ff(thr));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer; read data and error are taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic close_out();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #200000;
      n_errors++;
      close_out();
   end

   initial begin
      step(2);
      chk({reg_on, rst_n, boost_ok, setpt, thr}, 32'h0);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         wake_req <= rows[i].w;
         low_good <= rows[i].lg;
         bat_good <= rows[i].bg;
         step(7);
         chk(reg_on, rows[i].on);
         chk(rst_n, rows[i].on);
      end
      // chip held in reset: settings writes are dropped
      apb(1'b1, `OFS_CTRL, 32'h00000001);
      apb(1'b0, `OFS_CTRL, 32'h00000000);
      chk(rd, 32'h0);
      wake_req <= 3'h1;
      bat_good <= 1'b1;
      uv <= 1'b1;
      step(7);
      chk(boost_ok, 1'b0);
      step(12);
      chk(boost_ok, 1'b1);
      uv <= 1'b0;
      apb(1'b1, `OFS_DRIVE, 32'h0000003F);
      step(2);
      chk(setpt, 4'hF);
      chk(thr, 3'h3);
      apb(1'b0, `OFS_DRIVE, 32'h00000000);
      chk(rd, 32'h0000003F);
      uv <= 1'b1;
      step(6);
      chk(boost_ok, 1'b0);
      uv <= 1'b0;
      apb(1'b1, `OFS_CTRL, 32'h00000001);
      apb(1'b0, `OFS_CTRL, 32'h00000000);
      chk(rd, 32'h00000001);
      wake_req <= 3'h0;
      step(7);
      chk({reg_on, rst_n}, 2'b11);
      apb(1'b1, `OFS_CTRL, 32'h00000000);
      step(7);
      chk({reg_on, rst_n}, 2'b00);
      wake_req <= 3'h2;
      step(7);
      apb(1'b0, `OFS_DRIVE, 32'h00000000);
      chk(rd, 32'h0);
      chk({setpt, thr}, 7'h00);
      apb(1'b0, 12'h010, 32'h00000000);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      presetn <= 1'b0;
      step(2);
      chk({reg_on, rst_n, boost_ok}, 3'b000);
      presetn <= 1'b1;
      step(7);
      chk({reg_on, rst_n}, 2'b11);
      close_out();
   end
endmodule // enable_and_drive_supply_supervisor_bench
